//--- pin_drive.sv
`timescale 1ns/100ps

module pin_drive (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic [1:0] code,
	input  wire logic [3:0] out_opt,
	input  wire logic [3:0] oe_n_opt,
	output logic            pin_out,
	output logic            pin_oe_n
);

	logic pin_out_q;
	logic pin_oe_n_q;

	// Picks the drive of the function that the code selects.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_out_q  <= pin_mux_pkg::PIN_OUT_RESET;
			pin_oe_n_q <= pin_mux_pkg::PIN_OE_N_RESET;
		end else begin
			pin_out_q  <= out_opt[code];
			pin_oe_n_q <= oe_n_opt[code];
		end
	end

	assign pin_out  = pin_out_q;
	assign pin_oe_n = pin_oe_n_q;

endmodule

//--- pin_mux_monitor.sv
`timescale 1ns/100ps

module pin_mux_monitor #(
	parameter int ADDR_W = 12
) (
	input wire logic              core_clk,
	input wire logic              arst_n,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic              pready,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic [6:0]        pin_in,
	input wire logic [6:0]        pin_out,
	input wire logic [6:0]        pin_oe_n,
	input wire logic [6:0]        gpio_out,
	input wire logic [6:0]        gpio_oe_n,
	input wire logic              serial_clock_out,
	input wire logic              serial_clock_oe_n,
	input wire logic              std_timer_output,
	input wire logic              shared_serial_data_out,
	input wire logic              serial_chip_select_out,
	input wire logic              serial_chip_select_oe_n,
	input wire logic              std_timer_inverted_output,
	input wire logic              shared_serial_data_in,
	input wire logic              crystal_osc_input
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	logic [7:0] sa_q;
	logic [7:0] sb_q;
	logic       done;
	logic       is_a;
	logic       is_b;

	assign done = psel && penable && pready;
	assign is_a = paddr == pin_mux_pkg::ADDR_PORT_A_SEL;
	assign is_b = paddr == pin_mux_pkg::ADDR_PORT_B_SEL;

	// Shadow copies of the selection registers, built from completed writes.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sa_q <= 8'h00;
			sb_q <= 8'h00;
		end else if (done && pwrite && is_a) begin
			sa_q <= pwdata[7:0];
		end else if (done && pwrite && is_b) begin
			sb_q <= pwdata[7:0] & pin_mux_pkg::PORT_B_SEL_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	chk_a7_serial_in: assert property (
		sa_q[7:6] == 2'h3 && $stable(sa_q) |=>
		shared_serial_data_in == $past(pin_in[6]))
		else $error("port A line 7 serial input not passed");
	chk_a6_serial_clk: assert property (
		sa_q[5:4] == 2'h2 && $stable(sa_q) |=>
		pin_out[5] == $past(serial_clock_out) &&
		pin_oe_n[5] == $past(serial_clock_oe_n))
		else $error("port A line 6 serial clock not driven");
	chk_a5_timer_out: assert property (
		sa_q[3:2] == 2'h1 && $stable(sa_q) |=>
		pin_out[4] == $past(std_timer_output) && !pin_oe_n[4])
		else $error("port A line 5 timer output not driven");
	chk_a4_crystal_in: assert property (
		sa_q[1:0] == 2'h3 && $stable(sa_q) |=>
		pin_oe_n[3] && crystal_osc_input == $past(pin_in[3]))
		else $error("port A line 4 crystal input wrong");
	chk_b3_data_out: assert property (
		sb_q[7:6] == 2'h3 && $stable(sb_q) |=>
		pin_out[2] == $past(shared_serial_data_out) && !pin_oe_n[2])
		else $error("port B line 3 serial data out not driven");
	chk_b2_chip_select: assert property (
		sb_q[5:4] == 2'h2 && $stable(sb_q) |=>
		pin_out[1] == $past(serial_chip_select_out) &&
		pin_oe_n[1] == $past(serial_chip_select_oe_n))
		else $error("port B line 2 chip select not driven");
	chk_b1_inverted_out: assert property (
		sb_q[3:2] == 2'h2 && $stable(sb_q) |=>
		pin_out[0] == $past(std_timer_inverted_output) && !pin_oe_n[0])
		else $error("port B line 1 inverted timer not driven");
	chk_b1_gpio_path: assert property (
		sb_q[3:2] != 2'h2 && $stable(sb_q) |=>
		pin_out[0] == $past(gpio_out[0]) &&
		pin_oe_n[0] == $past(gpio_oe_n[0]))
		else $error("port B line 1 general purpose path wrong");
	chk_reg_read_back: assert property (
		done && !pwrite && (is_a || is_b) |->
		prdata == {24'h000000, is_a ? sa_q : sb_q})
		else $error("selection register read back wrong");

	cover_a7_serial: cover property (sa_q[7:6] == 2'h3 && pin_in[6]);
	cover_a4_crystal: cover property (sa_q[1:0] == 2'h3);
	cover_b_read: cover property (done && !pwrite && is_b && sb_q != 8'h00);
endmodule

//--- pin_mux_peer.sv
`timescale 1ns/100ps

// Stands in for the peripherals, the port controller and the board pins.
module pin_mux_peer (
	input  wire logic [27:0] stim,
	input  wire logic [6:0]  ext_level,
	input  wire logic [6:0]  pin_out,
	input  wire logic [6:0]  pin_oe_n,
	output logic      [27:0] drv,
	output logic      [6:0]  pin_in
);
	// A released pin shows the board level, a driven pin its own drive.
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
		end
	end

	assign drv = stim;
endmodule

//--- pin_mux_pkg.sv
package pin_mux_pkg;

	// Register byte addresses on the APB bus.
	localparam logic [11:0] ADDR_PORT_A_SEL = 12'h000;
	localparam logic [11:0] ADDR_PORT_B_SEL = 12'h004;

	// Reset values and writable bits of the selection registers.
	localparam logic [7:0] PORT_A_SEL_RESET = 8'h00;
	localparam logic [7:0] PORT_B_SEL_RESET = 8'h00;
	localparam logic [7:0] PORT_A_SEL_MASK  = 8'hFF;
	localparam logic [7:0] PORT_B_SEL_MASK  = 8'hFC;

	// Field positions (least significant bit of each 2-bit field).
	localparam int LSB_A7 = 6;
	localparam int LSB_A6 = 4;
	localparam int LSB_A5 = 2;
	localparam int LSB_A4 = 0;
	localparam int LSB_B3 = 6;
	localparam int LSB_B2 = 4;
	localparam int LSB_B1 = 2;

	// Pin positions in the pin vectors.
	localparam int NUM_PINS = 7;
	localparam int IDX_B1   = 0;
	localparam int IDX_B2   = 1;
	localparam int IDX_B3   = 2;
	localparam int IDX_A4   = 3;
	localparam int IDX_A5   = 4;
	localparam int IDX_A6   = 5;
	localparam int IDX_A7   = 6;

	// Selection codes.
	localparam logic [1:0] CODE_00 = 2'h0;
	localparam logic [1:0] CODE_01 = 2'h1;
	localparam logic [1:0] CODE_10 = 2'h2;
	localparam logic [1:0] CODE_11 = 2'h3;

	// Reset levels of the pin drivers and idle chip-select level.
	localparam logic PIN_OUT_RESET  = 1'b0;
	localparam logic PIN_OE_N_RESET = 1'b1;
	localparam logic SELECT_IDLE    = 1'b1;

	// APB bus answer states.
	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_ANSWER
	} bus_state_t;

endpackage

//--- port_pin_function_mux.sv
`timescale 1ns/100ps


module port_pin_function_mux #(
	parameter int ADDR_W = 12
) (
	input  wire logic                  core_clk,
	input  wire logic                  arst_n,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [6:0]            pin_in,
	output logic      [6:0]            pin_out,
	output logic      [6:0]            pin_oe_n,
	input  wire logic [6:0]            gpio_out,
	input  wire logic [6:0]            gpio_oe_n,
	output logic      [6:0]            gpio_in,
	input  wire logic                  shared_serial_data_drive,
	input  wire logic                  shared_serial_data_drive_oe_n,
	input  wire logic                  serial_clock_out,
	input  wire logic                  serial_clock_oe_n,
	input  wire logic                  std_timer_output,
	input  wire logic                  serial_port_a_clock_out,
	input  wire logic                  serial_port_a_clock_oe_n,
	input  wire logic                  timer2_output,
	input  wire logic                  serial_port_a_select_out,
	input  wire logic                  serial_port_a_select_oe_n,
	input  wire logic                  shared_serial_data_out,
	input  wire logic                  serial_chip_select_out,
	input  wire logic                  serial_chip_select_oe_n,
	input  wire logic                  std_timer_inverted_output,
	output logic                       timer2_clock_input,
	output logic                       shared_serial_data_in,
	output logic                       std_timer_clock_input,
	output logic                       serial_port_a_data_in,
	output logic                       serial_clock_in,
	output logic                       std_timer_capture_input,
	output logic                       serial_port_a_clock_in,
	output logic                       timer2_capture_input,
	output logic                       serial_port_a_select_in,
	output logic                       crystal_osc_input,
	output logic                       serial_chip_select_in,
	output logic                       external_irq1_input
);

	////////////////////////////////////////////////////////////////////////
	// Declarations.

	logic [7:0] port_a_sel;
	logic [7:0] port_b_sel;
	logic [1:0] code_a7;
	logic [1:0] code_a6;
	logic [1:0] code_a5;
	logic [1:0] code_a4;
	logic [1:0] code_b3;
	logic [1:0] code_b2;
	logic [1:0] code_b1;

	logic [6:0] gpio_in_q;
	logic       timer2_clock_input_q;
	logic       shared_serial_data_in_q;
	logic       std_timer_clock_input_q;
	logic       serial_port_a_data_in_q;
	logic       serial_clock_in_q;
	logic       std_timer_capture_input_q;
	logic       serial_port_a_clock_in_q;
	logic       timer2_capture_input_q;
	logic       serial_port_a_select_in_q;
	logic       crystal_osc_input_q;
	logic       serial_chip_select_in_q;
	logic       external_irq1_input_q;

	// Extracts one 2-bit selection field from a register.
	function automatic logic [1:0] field(
		input logic [7:0] sel_reg,
		input int         lsb
	);
		return sel_reg[lsb +: 2];
	endfunction

	// True when the field holds either of two codes.
	function automatic logic code_is(
		input logic [1:0] code,
		input logic [1:0] first,
		input logic [1:0] second
	);
		return (code == first) || (code == second);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register file on the APB bus.

	select_regs #(
		.ADDR_W (ADDR_W)
	) u_regs (
		.core_clk   (core_clk),
		.arst_n     (arst_n),
		.psel       (psel),
		.penable    (penable),
		.pwrite     (pwrite),
		.paddr      (paddr),
		.pwdata     (pwdata),
		.prdata     (prdata),
		.pready     (pready),
		.pslverr    (pslverr),
		.port_a_sel (port_a_sel),
		.port_b_sel (port_b_sel)
	);

	assign code_a7 = field(port_a_sel, pin_mux_pkg::LSB_A7);
	assign code_a6 = field(port_a_sel, pin_mux_pkg::LSB_A6);
	assign code_a5 = field(port_a_sel, pin_mux_pkg::LSB_A5);
	assign code_a4 = field(port_a_sel, pin_mux_pkg::LSB_A4);
	assign code_b3 = field(port_b_sel, pin_mux_pkg::LSB_B3);
	assign code_b2 = field(port_b_sel, pin_mux_pkg::LSB_B2);
	assign code_b1 = field(port_b_sel, pin_mux_pkg::LSB_B1);

	////////////////////////////////////////////////////////////////////////
	// Pin drivers. Option vectors are ordered {code 11, 10, 01, 00}.
	// Where a GPIO role shares a pin with a digital input, the GPIO
	// direction decides the drive, so software must set it to input.

	pin_drive u_a7 (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.code     (code_a7),
		.out_opt  ({shared_serial_data_drive,
			{3{gpio_out[pin_mux_pkg::IDX_A7]}}}),
		.oe_n_opt ({shared_serial_data_drive_oe_n,
			{3{gpio_oe_n[pin_mux_pkg::IDX_A7]}}}),
		.pin_out  (pin_out[pin_mux_pkg::IDX_A7]),
		.pin_oe_n (pin_oe_n[pin_mux_pkg::IDX_A7])
	);

	pin_drive u_a6 (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.code     (code_a6),
		.out_opt  ({gpio_out[pin_mux_pkg::IDX_A6], serial_clock_out,
			1'b0, gpio_out[pin_mux_pkg::IDX_A6]}),
		.oe_n_opt ({gpio_oe_n[pin_mux_pkg::IDX_A6], serial_clock_oe_n,
			1'b1, gpio_oe_n[pin_mux_pkg::IDX_A6]}),
		.pin_out  (pin_out[pin_mux_pkg::IDX_A6]),
		.pin_oe_n (pin_oe_n[pin_mux_pkg::IDX_A6])
	);

	pin_drive u_a5 (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.code     (code_a5),
		.out_opt  ({gpio_out[pin_mux_pkg::IDX_A5],
			serial_port_a_clock_out, std_timer_output,
			gpio_out[pin_mux_pkg::IDX_A5]}),
		.oe_n_opt ({gpio_oe_n[pin_mux_pkg::IDX_A5],
			serial_port_a_clock_oe_n, 1'b0,
			gpio_oe_n[pin_mux_pkg::IDX_A5]}),
		.pin_out  (pin_out[pin_mux_pkg::IDX_A5]),
		.pin_oe_n (pin_oe_n[pin_mux_pkg::IDX_A5])
	);

	pin_drive u_a4 (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.code     (code_a4),
		.out_opt  ({1'b0, serial_port_a_select_out, timer2_output,
			gpio_out[pin_mux_pkg::IDX_A4]}),
		.oe_n_opt ({1'b1, serial_port_a_select_oe_n, 1'b0,
			gpio_oe_n[pin_mux_pkg::IDX_A4]}),
		.pin_out  (pin_out[pin_mux_pkg::IDX_A4]),
		.pin_oe_n (pin_oe_n[pin_mux_pkg::IDX_A4])
	);

	pin_drive u_b3 (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.code     (code_b3),
		.out_opt  ({shared_serial_data_out, 1'b0,
			{2{gpio_out[pin_mux_pkg::IDX_B3]}}}),
		.oe_n_opt ({1'b0, 1'b1,
			{2{gpio_oe_n[pin_mux_pkg::IDX_B3]}}}),
		.pin_out  (pin_out[pin_mux_pkg::IDX_B3]),
		.pin_oe_n (pin_oe_n[pin_mux_pkg::IDX_B3])
	);

	pin_drive u_b2 (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.code     (code_b2),
		.out_opt  ({serial_port_a_clock_out, serial_chip_select_out,
			{2{gpio_out[pin_mux_pkg::IDX_B2]}}}),
		.oe_n_opt ({serial_port_a_clock_oe_n, serial_chip_select_oe_n,
			{2{gpio_oe_n[pin_mux_pkg::IDX_B2]}}}),
		.pin_out  (pin_out[pin_mux_pkg::IDX_B2]),
		.pin_oe_n (pin_oe_n[pin_mux_pkg::IDX_B2])
	);

	pin_drive u_b1 (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.code     (code_b1),
		.out_opt  ({gpio_out[pin_mux_pkg::IDX_B1],
			std_timer_inverted_output,
			{2{gpio_out[pin_mux_pkg::IDX_B1]}}}),
		.oe_n_opt ({gpio_oe_n[pin_mux_pkg::IDX_B1], 1'b0,
			{2{gpio_oe_n[pin_mux_pkg::IDX_B1]}}}),
		.pin_out  (pin_out[pin_mux_pkg::IDX_B1]),
		.pin_oe_n (pin_oe_n[pin_mux_pkg::IDX_B1])
	);

	////////////////////////////////////////////////////////////////////////
	// Port A input routing to the peripherals. A deselected input reads
	// its idle level so a peripheral sees no edges from a foreign pin.

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			timer2_clock_input_q    <= 1'b0;
			shared_serial_data_in_q <= 1'b0;
			std_timer_clock_input_q <= 1'b0;
			serial_clock_in_q       <= 1'b0;
		end else begin
			timer2_clock_input_q <= (code_a7 != pin_mux_pkg::CODE_11) &&
				pin_in[pin_mux_pkg::IDX_A7];
			shared_serial_data_in_q <= (code_a7 == pin_mux_pkg::CODE_11) &&
				pin_in[pin_mux_pkg::IDX_A7];
			std_timer_clock_input_q <= code_is(code_a6,
				pin_mux_pkg::CODE_00, pin_mux_pkg::CODE_11) &&
				pin_in[pin_mux_pkg::IDX_A6];
			serial_clock_in_q <= (code_a6 == pin_mux_pkg::CODE_10) &&
				pin_in[pin_mux_pkg::IDX_A6];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			std_timer_capture_input_q <= 1'b0;
			timer2_capture_input_q    <= 1'b0;
			serial_port_a_select_in_q <= pin_mux_pkg::SELECT_IDLE;
			crystal_osc_input_q       <= 1'b0;
		end else begin
			std_timer_capture_input_q <= code_is(code_a5,
				pin_mux_pkg::CODE_00, pin_mux_pkg::CODE_11) &&
				pin_in[pin_mux_pkg::IDX_A5];
			timer2_capture_input_q <= (code_a4 == pin_mux_pkg::CODE_00) &&
				pin_in[pin_mux_pkg::IDX_A4];
			serial_port_a_select_in_q <=
				(code_a4 == pin_mux_pkg::CODE_10) ?
				pin_in[pin_mux_pkg::IDX_A4] :
				pin_mux_pkg::SELECT_IDLE;
			crystal_osc_input_q <= (code_a4 == pin_mux_pkg::CODE_11) &&
				pin_in[pin_mux_pkg::IDX_A4];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Inputs that two pins can feed; the port A pin takes precedence.

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			serial_port_a_data_in_q  <= 1'b0;
			serial_port_a_clock_in_q <= 1'b0;
		end else begin
			if (code_a6 == pin_mux_pkg::CODE_01) begin
				serial_port_a_data_in_q <= pin_in[pin_mux_pkg::IDX_A6];
			end else if (code_b3 == pin_mux_pkg::CODE_10) begin
				serial_port_a_data_in_q <= pin_in[pin_mux_pkg::IDX_B3];
			end else begin
				serial_port_a_data_in_q <= 1'b0;
			end
			if (code_a5 == pin_mux_pkg::CODE_10) begin
				serial_port_a_clock_in_q <= pin_in[pin_mux_pkg::IDX_A5];
			end else if (code_b2 == pin_mux_pkg::CODE_11) begin
				serial_port_a_clock_in_q <= pin_in[pin_mux_pkg::IDX_B2];
			end else begin
				serial_port_a_clock_in_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Port B input routing and GPIO input readback.

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			serial_chip_select_in_q <= pin_mux_pkg::SELECT_IDLE;
			external_irq1_input_q   <= 1'b0;
			gpio_in_q               <= 7'h00;
		end else begin
			serial_chip_select_in_q <=
				(code_b2 == pin_mux_pkg::CODE_10) ?
				pin_in[pin_mux_pkg::IDX_B2] :
				pin_mux_pkg::SELECT_IDLE;
			external_irq1_input_q <= (code_b1 != pin_mux_pkg::CODE_10) &&
				pin_in[pin_mux_pkg::IDX_B1];
			gpio_in_q <= pin_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign gpio_in                 = gpio_in_q;
	assign timer2_clock_input      = timer2_clock_input_q;
	assign shared_serial_data_in   = shared_serial_data_in_q;
	assign std_timer_clock_input   = std_timer_clock_input_q;
	assign serial_port_a_data_in   = serial_port_a_data_in_q;
	assign serial_clock_in         = serial_clock_in_q;
	assign std_timer_capture_input = std_timer_capture_input_q;
	assign serial_port_a_clock_in  = serial_port_a_clock_in_q;
	assign timer2_capture_input    = timer2_capture_input_q;
	assign serial_port_a_select_in = serial_port_a_select_in_q;
	assign crystal_osc_input       = crystal_osc_input_q;
	assign serial_chip_select_in   = serial_chip_select_in_q;
	assign external_irq1_input     = external_irq1_input_q;

endmodule

//--- select_regs.sv
`timescale 1ns/100ps

module select_regs #(
	parameter int ADDR_W = 12
) (
	input  wire logic              core_clk,
	input  wire logic              arst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic      [7:0]        port_a_sel,
	output logic      [7:0]        port_b_sel
);

	pin_mux_pkg::bus_state_t state_q;
	logic [31:0]             prdata_q;
	logic                    pready_q;
	logic                    pslverr_q;
	logic [7:0]              port_a_sel_q;
	logic [7:0]              port_b_sel_q;
	logic                    hit_a;
	logic                    hit_b;
	logic                    done;

	assign hit_a = paddr == ADDR_W'(pin_mux_pkg::ADDR_PORT_A_SEL);
	assign hit_b = paddr == ADDR_W'(pin_mux_pkg::ADDR_PORT_B_SEL);
	assign done  = psel && penable && pready_q;

	////////////////////////////////////////////////////////////////////////
	// Each access phase gets one wait state; the answer is registered.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q   <= pin_mux_pkg::BUS_IDLE;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end else begin
			case (state_q)
				pin_mux_pkg::BUS_IDLE: begin
					if (psel && penable) begin
						state_q   <= pin_mux_pkg::BUS_ANSWER;
						pready_q  <= 1'b1;
						pslverr_q <= !(hit_a || hit_b);
						prdata_q  <= 32'h00000000;
						if (!pwrite && hit_a) begin
							prdata_q[7:0] <= port_a_sel_q;
						end
						if (!pwrite && hit_b) begin
							prdata_q[7:0] <= port_b_sel_q;
						end
					end
				end
				pin_mux_pkg::BUS_ANSWER: begin
					state_q   <= pin_mux_pkg::BUS_IDLE;
					pready_q  <= 1'b0;
					pslverr_q <= 1'b0;
					prdata_q  <= 32'h00000000;
				end
				default: begin
					state_q  <= pin_mux_pkg::BUS_IDLE;
					pready_q <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Selection registers; unimplemented port B bits stay zero.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			port_a_sel_q <= pin_mux_pkg::PORT_A_SEL_RESET;
			port_b_sel_q <= pin_mux_pkg::PORT_B_SEL_RESET;
		end else if (done && pwrite) begin
			if (hit_a) begin
				port_a_sel_q <= pwdata[7:0] & pin_mux_pkg::PORT_A_SEL_MASK;
			end
			if (hit_b) begin
				port_b_sel_q <= pwdata[7:0] & pin_mux_pkg::PORT_B_SEL_MASK;
			end
		end
	end

	assign prdata     = prdata_q;
	assign pready     = pready_q;
	assign pslverr    = pslverr_q;
	assign port_a_sel = port_a_sel_q;
	assign port_b_sel = port_b_sel_q;

endmodule

//--- tb.sv
`timescale 1ns/100ps

module tb;
	localparam int          ADDR_W = 12;
	localparam logic [27:0] IDLE   = 28'hFE0124A;
	logic              core_clk;
	logic              arst_n;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [6:0]        pin_in;
	logic [6:0]        pin_out;
	logic [6:0]        pin_oe_n;
	logic [6:0]        gpio_in;
	logic [27:0]       stim;
	logic [27:0]       drv;
	logic [6:0]        ext_level;
	logic [11:0]       per_in;
	int                fails;
	int                tests_run;

	pin_mux_peer peer (.stim(stim), .ext_level(ext_level), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .drv(drv), .pin_in(pin_in));

	port_pin_function_mux #(.ADDR_W(ADDR_W)) uut (.core_clk(core_clk),
		.arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .gpio_out(drv[20:14]), .gpio_oe_n(drv[27:21]),
		.gpio_in(gpio_in), .shared_serial_data_drive(drv[0]),
		.shared_serial_data_drive_oe_n(drv[1]), .serial_clock_out(drv[2]),
		.serial_clock_oe_n(drv[3]), .std_timer_output(drv[4]),
		.serial_port_a_clock_out(drv[5]), .serial_port_a_clock_oe_n(drv[6]),
		.timer2_output(drv[7]), .serial_port_a_select_out(drv[8]),
		.serial_port_a_select_oe_n(drv[9]), .shared_serial_data_out(drv[10]),
		.serial_chip_select_out(drv[11]), .serial_chip_select_oe_n(drv[12]),
		.std_timer_inverted_output(drv[13]),
		.timer2_clock_input(per_in[11]), .shared_serial_data_in(per_in[10]),
		.std_timer_clock_input(per_in[9]), .serial_port_a_data_in(per_in[8]),
		.serial_clock_in(per_in[7]), .std_timer_capture_input(per_in[6]),
		.serial_port_a_clock_in(per_in[5]), .timer2_capture_input(per_in[4]),
		.serial_port_a_select_in(per_in[3]), .crystal_osc_input(per_in[2]),
		.serial_chip_select_in(per_in[1]), .external_irq1_input(per_in[0]));

	initial begin
		core_clk = 1'h0;
		forever #25 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		int n;
		psel    <= 1'h1;
		penable <= 1'h0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		n = 0;
		// The answer is read where it is settled, ahead of its edge.
		do begin
			@(negedge core_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd = prdata;
		err = pslverr;
		@(posedge core_clk);
		psel    <= 1'h0;
		penable <= 1'h0;
		if (n >= 20) begin
			fails++;
			end_of_test();
		end
		@(posedge core_clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset_map();
		logic [31:0] rd;
		logic        err;
		apb(pin_mux_pkg::ADDR_PORT_A_SEL, 1'h0, 32'h0, rd, err);
		check("port a select reset", 32'h0, rd);
		apb(pin_mux_pkg::ADDR_PORT_B_SEL, 1'h0, 32'h0, rd, err);
		check("port b select reset", 32'h0, rd);
		apb(12'h008, 1'h1, 32'hFF, rd, err);
		check("unmapped write error", 32'h1, {31'h0, err});
		apb(12'h008, 1'h0, 32'h0, rd, err);
		check("unmapped read data", 32'h0, rd);
		check("unmapped read error", 32'h1, {31'h0, err});
		apb(pin_mux_pkg::ADDR_PORT_A_SEL, 1'h0, 32'h0, rd, err);
		check("port a after unmapped", 32'h0, rd);
	endtask

	task automatic t_mid_reset();
		logic [31:0] rd;
		logic        err;
		arst_n <= 1'h0;
		repeat (2) @(posedge core_clk);
		check("pin enable in reset", 32'h7F, {25'h0, pin_oe_n});
		check("periph in reset", 32'h00A, {20'h0, per_in});
		arst_n <= 1'h1;
		@(posedge core_clk);
		apb(pin_mux_pkg::ADDR_PORT_A_SEL, 1'h0, 32'h0, rd, err);
		check("port a select after reset", 32'h0, rd);
		apb(pin_mux_pkg::ADDR_PORT_B_SEL, 1'h0, 32'h0, rd, err);
		check("port b select after reset", 32'h0, rd);
	endtask

	task automatic t_codes();
		logic [27:0] pat [3];
		logic [6:0]  lvl [3];
		logic [31:0] rd;
		logic        err;
		logic [1:0]  c;
		logic        z;
		logic        o;
		logic        t;
		logic        h;
		logic [13:0] d;
		logic [6:0]  eo;
		logic [6:0]  en;
		logic [6:0]  p;
		logic [11:0] ei;
		// The third pattern sets every GPIO direction to input; selected functions still drive their pins.
		pat = '{28'h5A3C96E, 28'hA5C3691, 28'hFE15AB5};
		lvl = '{7'h2B, 7'h54, 7'h69};
		for (int k = 0; k < 4; k++) begin
			c = 2'(k);
			stim <= IDLE;
			apb(pin_mux_pkg::ADDR_PORT_A_SEL, 1'h1, {24'h0, {4{c}}}, rd, err);
			apb(pin_mux_pkg::ADDR_PORT_B_SEL, 1'h1, {24'h0, {4{c}}}, rd, err);
			apb(pin_mux_pkg::ADDR_PORT_A_SEL, 1'h0, 32'h0, rd, err);
			check("port a select", {24'h0, {4{c}}}, rd);
			apb(pin_mux_pkg::ADDR_PORT_B_SEL, 1'h0, 32'h0, rd, err);
			check("port b select", {24'h0, {3{c}}, 2'h0}, rd);
			z = c == 2'h0;
			o = c == 2'h1;
			t = c == 2'h2;
			h = c == 2'h3;
			for (int j = 0; j < 3; j++) begin
				stim <= pat[j];
				ext_level <= lvl[j];
				repeat (4) @(posedge core_clk);
				d = pat[j][13:0];
				eo = pat[j][20:14];
				en = pat[j][27:21];
				if (o) begin
					eo[5:3] = {1'h0, d[4], d[7]};
					en[5:3] = 3'h4;
				end else if (t) begin
					eo[5:0] = {d[2], d[5], d[8], 1'h0, d[11], d[13]};
					en[5:0] = {d[3], d[6], d[9], 1'h1, d[12], 1'h0};
				end else if (h) begin
					eo[6] = d[0];
					en[6] = d[1];
					eo[3:1] = {1'h0, d[10], d[5]};
					en[3:1] = {1'h1, 1'h0, d[6]};
				end
				p = (en & lvl[j]) | (~en & eo);
				ei = {~h & p[6], h & p[6], (z | h) & p[5],
					(o & p[5]) | (t & p[2]), t & p[5], (z | h) & p[4],
					(t & p[4]) | (h & p[1]), z & p[3], ~t | p[3],
					h & p[3], ~t | p[1], ~t & p[0]};
				check("pin drive", {25'h0, eo}, {25'h0, pin_out});
				check("pin enable", {25'h0, en}, {25'h0, pin_oe_n});
				check("peripheral inputs", {20'h0, ei}, {20'h0, per_in});
				check("port input", {25'h0, p}, {25'h0, gpio_in});
			end
		end
	endtask

	initial begin
		fails = 0;
		tests_run = 0;
		arst_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		stim = IDLE;
		ext_level = 7'h00;
		repeat (5) @(posedge core_clk);
		arst_n <= 1'h1;
		@(posedge core_clk);
		t_reset_map();
		t_codes();
		t_mid_reset();
		end_of_test();
	end
endmodule

bind port_pin_function_mux pin_mux_monitor #(.ADDR_W(ADDR_W)) mon (
	.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pin_in(pin_in), .pin_out(pin_out),
	.pin_oe_n(pin_oe_n), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
	.serial_clock_out(serial_clock_out),
	.serial_clock_oe_n(serial_clock_oe_n),
	.std_timer_output(std_timer_output),
	.shared_serial_data_out(shared_serial_data_out),
	.serial_chip_select_out(serial_chip_select_out),
	.serial_chip_select_oe_n(serial_chip_select_oe_n),
	.std_timer_inverted_output(std_timer_inverted_output),
	.shared_serial_data_in(shared_serial_data_in),
	.crystal_osc_input(crystal_osc_input));
